// ===== dccb_core_ctl.sv
`timescale 1ns/1ns
// Core control register with override, safeload and rate logic
module dccb_core_ctl
  import dccb_pkg::*;
#(
  parameter int DEB_CYC_00_P = DEB_CYC_00,
  parameter int DEB_CYC_01_P = DEB_CYC_01,
  parameter int DEB_CYC_10_P = DEB_CYC_10,
  parameter int DEB_CYC_11_P = DEB_CYC_11
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control port
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [dccb_pkg::ADDR_W-1:0] addr_i,
  input wire logic [dccb_pkg::DATA_W-1:0] wdata_i,
  output logic [dccb_pkg::DATA_W-1:0] rdata_o,
  // Program side and pins
  input wire logic dsp_if_we_i,
  input wire logic [2:0] dsp_if_idx_i,
  input wire logic [dccb_pkg::DATA_W-1:0] dsp_if_data_i,
  input wire logic [dccb_pkg::GPIO_W-1:0] gpio_pin_i,
  input wire logic [dccb_pkg::AUX_N-1:0][dccb_pkg::AUX_W-1:0] aux_adc_i,
  // Register contents
  output logic [dccb_pkg::IF_N-1:0][dccb_pkg::DATA_W-1:0] if_regs_o,
  output logic [dccb_pkg::GPIO_W-1:0] gpio_setting_o,
  output logic [dccb_pkg::AUX_N-1:0][dccb_pkg::AUX_W-1:0] aux_data_o,
  // Converter and core control
  output logic adc_unmute_o,
  output logic dac_unmute_o,
  output logic core_run_not_clear_o,
  output logic [1:0] rate_multiplier_o,
  output logic [10:0] instr_per_sample_o,
  // Parameter RAM write
  output logic pram_we_o,
  output logic [dccb_pkg::PRAM_AW-1:0] pram_addr_o,
  output logic [dccb_pkg::DATA_W-1:0] pram_data_o
);
  import dccb_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] ctl;
    logic [IF_N-1:0][DATA_W-1:0] ifr;
    logic [GPIO_W-1:0] gpio;
    logic [GPIO_W-1:0][DEB_CNT_W-1:0] cnt;
    logic [AUX_N-1:0][AUX_W-1:0] aux;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rate;
    logic [10:0] ipf;
  } dccb_st_t;
  dccb_st_t st_ff, nxt_st;
  dccb_sl_if sl ();
  // Write strobes per register group
  logic wr_ctl;
  logic wr_if;
  logic wr_gpio;
  logic wr_aux;
  logic [DEB_CNT_W-1:0] deb_lim;
  logic [ADDR_W-1:0] if_off;
  logic [ADDR_W-1:0] aux_off;
  logic [ADDR_W-1:0] sld_off;
  logic [ADDR_W-1:0] sla_off;

  // Address decode for host writes
  always_comb
  begin
    wr_ctl = 1'b0;
    wr_if = 1'b0;
    wr_gpio = 1'b0;
    wr_aux = 1'b0;
    if_off = addr_i - IF_BASE;
    aux_off = addr_i - AUX_BASE;
    sld_off = addr_i - SL_DATA_BASE;
    sla_off = addr_i - SL_ADDR_BASE;
    // Safeload pairs decode in their own process below
    if (!wr_i)
      wr_ctl = 1'b0;
    else if (addr_i == CORE_CTL)
      wr_ctl = 1'b1;
    else if (addr_i >= IF_BASE && addr_i <= IF_LAST)
      wr_if = 1'b1;
    else if (addr_i == GPIO_SET)
      wr_gpio = 1'b1;
    else if (addr_i >= AUX_BASE && addr_i <= AUX_LAST)
      wr_aux = 1'b1;
  end

  // debounce time from the select field
  always_comb
  begin
    case (st_ff.ctl[GD_LSB +: 2])
      2'h0: deb_lim = DEB_CNT_W'(DEB_CYC_00_P);
      2'h1: deb_lim = DEB_CNT_W'(DEB_CYC_01_P);
      2'h2: deb_lim = DEB_CNT_W'(DEB_CYC_10_P);
      default: deb_lim = DEB_CNT_W'(DEB_CYC_11_P);
    endcase
  end

  // Safeload pair writes go straight to the engine
  always_comb
  begin
    sl.wr = 1'b0;
    sl.is_addr = 1'b0;
    sl.idx = '0;
    sl.wdata = wdata_i;
    // Start is a level; the engine ignores it in its done cycle
    sl.start = st_ff.ctl[IST_BIT];
    if (wr_i && addr_i >= SL_DATA_BASE && addr_i <= SL_DATA_LAST)
    begin
      sl.wr = 1'b1;
      sl.idx = sld_off[SL_IDX_W-1:0];
    end
    else if (wr_i && addr_i >= SL_ADDR_BASE && addr_i <= SL_ADDR_LAST)
    begin
      sl.wr = 1'b1;
      sl.is_addr = 1'b1;
      sl.idx = sla_off[SL_IDX_W-1:0];
    end
  end

  // Next state of every register
  always_comb
  begin
    nxt_st = st_ff;
    // mute and clear bits written as plain fields
    if (wr_ctl)
      nxt_st.ctl = (wdata_i & CTL_WMASK) | (st_ff.ctl & ~CTL_WMASK);
    // self clear on done; a new set wins
    // bit stays 1 until the copy ends
    nxt_st.ctl[IST_BIT] = (st_ff.ctl[IST_BIT] & ~sl.done) | (wr_ctl & wdata_i[IST_BIT]);
    if (dsp_if_we_i && !st_ff.ctl[INTERFACE_REGS_HOST_WRITE_BIT])
      nxt_st.ifr[dsp_if_idx_i] = dsp_if_data_i;
    if (wr_if && st_ff.ctl[INTERFACE_REGS_HOST_WRITE_BIT])
      nxt_st.ifr[if_off[2:0]] = wdata_i;
    // A bounce back to the old level restarts the count
    // per pin filter, new level must hold for the full time
    for (int i = 0; i < GPIO_W; i++)
    begin
      if (gpio_pin_i[i] == st_ff.gpio[i] || st_ff.ctl[PIN_SETTING_HOST_WRITE_BIT])
        nxt_st.cnt[i] = '0;
      else if (st_ff.cnt[i] >= deb_lim - 1'b1)
      begin
        nxt_st.cnt[i] = '0;
        nxt_st.gpio[i] = gpio_pin_i[i];
      end
      else
        nxt_st.cnt[i] = st_ff.cnt[i] + 1'b1;
    end
    // override stops pin tracking, host owns the register
    if (wr_gpio && st_ff.ctl[PIN_SETTING_HOST_WRITE_BIT])
      nxt_st.gpio = wdata_i[GPIO_W-1:0];
    // aux data from converter unless overridden
    if (!st_ff.ctl[AUX_CONV_DATA_HOST_WRITE_BIT])
      nxt_st.aux = aux_adc_i;
    else if (wr_aux)
      nxt_st.aux[aux_off[1:0]] = wdata_i[AUX_W-1:0];
    // Registered so rate and count switch together
    // reserved code falls back to 1x timing
    case (st_ff.ctl[SR_LSB +: 2])
      RATE_1X:
      begin
        nxt_st.ipf = IPF_1X;
        nxt_st.rate = RATE_1X;
      end
      RATE_2X:
      begin
        nxt_st.ipf = IPF_2X;
        nxt_st.rate = RATE_2X;
      end
      RATE_4X:
      begin
        nxt_st.ipf = IPF_4X;
        nxt_st.rate = RATE_4X;
      end
      default:
      begin
        nxt_st.ipf = IPF_1X;
        nxt_st.rate = RATE_1X;
      end
    endcase
    // Safeload pairs are write only and read back as zero
    // Read data lands one cycle after the strobe; unmapped reads 0
    if (!rd_i)
      nxt_st.rdata = st_ff.rdata;
    else if (addr_i == CORE_CTL)
      nxt_st.rdata = st_ff.ctl;
    else if (addr_i >= IF_BASE && addr_i <= IF_LAST)
      nxt_st.rdata = st_ff.ifr[if_off[2:0]];
    else if (addr_i == GPIO_SET)
      nxt_st.rdata = DATA_W'(st_ff.gpio);
    else if (addr_i >= AUX_BASE && addr_i <= AUX_LAST)
      nxt_st.rdata = DATA_W'(st_ff.aux[aux_off[1:0]]);
    else
      nxt_st.rdata = '0;
  end

  // State register; reset clears mutes to muted and core held
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_ff <= '0;
      st_ff.ctl <= CTL_RESET;
      st_ff.ipf <= IPF_1X;
    end
    else
      st_ff <= nxt_st;
  end

  // Copy engine
  dccb_safeload u_safeload (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sl(sl.eng)
  );

  // Outputs are flop fields
  assign rdata_o = st_ff.rdata;
  assign if_regs_o = st_ff.ifr;
  assign gpio_setting_o = st_ff.gpio;
  assign aux_data_o = st_ff.aux;
  assign adc_unmute_o = st_ff.ctl[ADM_BIT];
  assign dac_unmute_o = st_ff.ctl[DAM_BIT];
  assign core_run_not_clear_o = st_ff.ctl[CR_BIT];
  assign rate_multiplier_o = st_ff.rate;
  assign instr_per_sample_o = st_ff.ipf;
  assign pram_we_o = sl.pram_we;
  assign pram_addr_o = sl.pram_addr;
  assign pram_data_o = sl.pram_data;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Trigger handshake with the copy engine
  trig_set_a: assert property (wr_ctl && wdata_i[IST_BIT] |=> st_ff.ctl[IST_BIT])
    else $error("trigger not set");
  trig_clear_a: assert property (sl.done && !wr_ctl |=> !st_ff.ctl[IST_BIT])
    else $error("trigger not cleared");
  trig_busy_a: assert property (sl.busy |-> st_ff.ctl[IST_BIT])
    else $error("trigger low while copying");
  trig_start_a: assert property (st_ff.ctl[IST_BIT] && !sl.busy && !sl.done |=> sl.busy)
    else $error("copy did not start");
  pram_we_a: assert property (pram_we_o |-> $past(sl.busy))
    else $error("parameter write outside a copy");
  // Mute and core clear bits follow the host
  adc_mute_a: assert property (wr_ctl && !wdata_i[ADM_BIT] |=> !adc_unmute_o)
    else $error("adc not muted");
  dac_mute_a: assert property (wr_ctl && !wdata_i[DAM_BIT] |=> !dac_unmute_o)
    else $error("dac not muted");
  core_clear_a: assert property (wr_ctl && !wdata_i[CR_BIT] |=> !core_run_not_clear_o)
    else $error("core not held");
  adc_pass_a: assert property (wr_ctl && wdata_i[ADM_BIT] |=> adc_unmute_o)
    else $error("adc not unmuted");
  dac_pass_a: assert property (wr_ctl && wdata_i[DAM_BIT] |=> dac_unmute_o)
    else $error("dac not unmuted");
  core_run_a: assert property (wr_ctl && wdata_i[CR_BIT] |=> core_run_not_clear_o)
    else $error("core not released");
  // Rate decode
  rate_1x_a: assert property (st_ff.ctl[1:0] == RATE_1X |=> instr_per_sample_o == 11'h0400)
    else $error("1x count wrong");
  rate_2x_a: assert property (st_ff.ctl[1:0] == RATE_2X |=> instr_per_sample_o == 11'h0200)
    else $error("2x count wrong");
  rate_4x_a: assert property (st_ff.ctl[1:0] == RATE_4X |=> instr_per_sample_o == 11'h0100)
    else $error("4x count wrong");
  rate_rsvd_a: assert property (st_ff.ctl[1:0] == 2'h3 |=> rate_multiplier_o == RATE_1X)
    else $error("reserved rate decoded");
  ipf_match_a: assert property (rate_multiplier_o == RATE_2X |-> instr_per_sample_o == IPF_2X)
    else $error("2x rate and count disagree");
  // Overrides, tracking and debounce
  if_block_a: assert property (st_ff.ctl[INTERFACE_REGS_HOST_WRITE_BIT] && !wr_ctl && !wr_if |=> $stable(if_regs_o))
    else $error("program wrote interface");
  if_host_a: assert property (st_ff.ctl[INTERFACE_REGS_HOST_WRITE_BIT] && wr_if |=> if_regs_o[$past(if_off[2:0])] == $past(wdata_i))
    else $error("host interface write lost");
  if_refuse_a: assert property (!st_ff.ctl[INTERFACE_REGS_HOST_WRITE_BIT] && wr_if && !dsp_if_we_i |=> $stable(if_regs_o))
    else $error("interface write taken without override");
  gpio_hold_a: assert property (st_ff.ctl[PIN_SETTING_HOST_WRITE_BIT] && !wr_gpio && !wr_ctl |=> $stable(gpio_setting_o))
    else $error("pin register tracked pins");
  gpio_host_a: assert property (st_ff.ctl[PIN_SETTING_HOST_WRITE_BIT] && wr_gpio |=> gpio_setting_o == $past(wdata_i[GPIO_W-1:0]))
    else $error("host pin write lost");
  aux_hold_a: assert property (st_ff.ctl[AUX_CONV_DATA_HOST_WRITE_BIT] && !wr_aux && !wr_ctl |=> $stable(aux_data_o))
    else $error("aux register tracked pins");
  aux_host_a: assert property (st_ff.ctl[AUX_CONV_DATA_HOST_WRITE_BIT] && wr_aux |=>
                               aux_data_o[$past(aux_off[1:0])] == $past(wdata_i[AUX_W-1:0]))
    else $error("host aux write lost");
  aux_track_a: assert property (!st_ff.ctl[AUX_CONV_DATA_HOST_WRITE_BIT] |=> aux_data_o == $past(aux_adc_i))
    else $error("aux register not tracking");
  deb_lim_a: assert property (st_ff.cnt[0] < deb_lim || $changed(deb_lim))
    else $error("debounce overran");
  gpio_follow_a: assert property (!st_ff.ctl[PIN_SETTING_HOST_WRITE_BIT] && gpio_pin_i[0] != gpio_setting_o[0] &&
                                  st_ff.cnt[0] >= deb_lim - 1'b1 |=> gpio_setting_o[0] == $past(gpio_pin_i[0]))
    else $error("settled pin not taken");
  // Coverage of the main scenarios
  copy_cov: cover property ($rose(sl.busy) ##[1:8] sl.done);
  unmute_cov: cover property (adc_unmute_o && dac_unmute_o && core_run_not_clear_o);
  rate4_cov: cover property (instr_per_sample_o == IPF_4X);
  rsvd_cov: cover property (st_ff.ctl[SR_LSB +: 2] == 2'h3);
  deb_cov: cover property (st_ff.ctl[GD_LSB +: 2] == 2'h1 && st_ff.cnt[0] == deb_lim - 1'b1);
endmodule // dccb_core_ctl

// ===== dccb_pkg.sv
// Notes on behaviour
// - Debounce code picks 20, 40, 10, 5 ms
// - Aux override: host writes aux data, pins ignored
// - Pin override: host writes pin setting register
// - Interface override: host writes interface registers
// - Interface override blocks program updates
// - Host sets trigger; device copies safeload pairs
// - Trigger clears itself when copy finishes
// - Five safeload address/data pairs exist
// - Only pairs written since last copy move
// - ADC unmute resets 0; 0 mutes ADCs
// - DAC unmute resets 0; 0 mutes DACs
// - Core run bit 0 holds core cleared
// - Rate 1x gives 1024 instructions per sample
// - Rate 2x gives 512 instructions, 96 kHz
// - Rate 4x gives 256 instructions, 192 kHz
// - Rate codes 00/01/10; 11 reserved
package dccb_pkg;
  // Control port word and address widths
  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  localparam int SL_N = 5;
  localparam int SL_IDX_W = 3;
  localparam int PRAM_AW = 10;
  localparam int IF_N = 8;
  localparam int AUX_N = 4;
  localparam int AUX_W = 12;
  localparam int GPIO_W = 12;
  // Register locations
  localparam logic [ADDR_W-1:0] IF_BASE = 12'h0800;
  localparam logic [ADDR_W-1:0] IF_LAST = 12'h0807;
  localparam logic [ADDR_W-1:0] GPIO_SET = 12'h0808;
  localparam logic [ADDR_W-1:0] AUX_BASE = 12'h0809;
  localparam logic [ADDR_W-1:0] AUX_LAST = 12'h080C;
  localparam logic [ADDR_W-1:0] SL_DATA_BASE = 12'h0810;
  localparam logic [ADDR_W-1:0] SL_DATA_LAST = 12'h0814;
  localparam logic [ADDR_W-1:0] SL_ADDR_BASE = 12'h0815;
  localparam logic [ADDR_W-1:0] SL_ADDR_LAST = 12'h0819;
  localparam logic [ADDR_W-1:0] CORE_CTL = 12'h081C;
  // Core control field positions
  localparam int GD_LSB = 12;
  localparam int AUX_CONV_DATA_HOST_WRITE_BIT = 8;
  localparam int PIN_SETTING_HOST_WRITE_BIT = 7;
  localparam int INTERFACE_REGS_HOST_WRITE_BIT = 6;
  localparam int IST_BIT = 5;
  localparam int ADM_BIT = 4;
  localparam int DAM_BIT = 3;
  localparam int CR_BIT = 2;
  localparam int SR_LSB = 0;
  localparam logic [DATA_W-1:0] CTL_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] CTL_WMASK = 16'h31DF;
  // Rate codes and instructions per sample
  localparam logic [1:0] RATE_1X = 2'h0;
  localparam logic [1:0] RATE_2X = 2'h1;
  localparam logic [1:0] RATE_4X = 2'h2;
  localparam logic [10:0] IPF_1X = 11'h0400;
  localparam logic [10:0] IPF_2X = 11'h0200;
  localparam logic [10:0] IPF_4X = 11'h0100;
  // Debounce times in ms and in clock cycles
  localparam int CLK_HZ = 50_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int DEB_MS_00 = 20;
  localparam int DEB_MS_01 = 40;
  localparam int DEB_MS_10 = 10;
  localparam int DEB_MS_11 = 5;
  localparam int DEB_CYC_00 = DEB_MS_00 * CYC_PER_MS;
  localparam int DEB_CYC_01 = DEB_MS_01 * CYC_PER_MS;
  localparam int DEB_CYC_10 = DEB_MS_10 * CYC_PER_MS;
  localparam int DEB_CYC_11 = DEB_MS_11 * CYC_PER_MS;
  localparam int DEB_CNT_W = 21;
endpackage

// ===== dccb_sl_if.sv
`timescale 1ns/1ns
// Safeload path between control logic and the copy engine
interface dccb_sl_if;
  import dccb_pkg::*;
  logic wr;
  logic is_addr;
  logic [SL_IDX_W-1:0] idx;
  logic [DATA_W-1:0] wdata;
  logic start;
  logic busy;
  logic done;
  logic pram_we;
  logic [PRAM_AW-1:0] pram_addr;
  logic [DATA_W-1:0] pram_data;
  modport ctl (output wr, is_addr, idx, wdata, start, input busy, done, pram_we, pram_addr, pram_data);
  modport eng (input wr, is_addr, idx, wdata, start, output busy, done, pram_we, pram_addr, pram_data);
endinterface

// ===== dccb_safeload.sv
`timescale 1ns/1ns
// Holds the safeload pairs and copies pending ones to parameter RAM
module dccb_safeload
  import dccb_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control side
  dccb_sl_if.eng sl
);
  typedef struct packed {
    logic [SL_N-1:0][PRAM_AW-1:0] addr;
    logic [SL_N-1:0][DATA_W-1:0] data;
    logic [SL_N-1:0] pend;
    logic busy;
    logic done;
    logic [SL_IDX_W-1:0] idx;
    logic we;
    logic [PRAM_AW-1:0] waddr;
    logic [DATA_W-1:0] wdata;
  } dccb_sl_st_t;
  dccb_sl_st_t st_ff, nxt_st;

  // Copy walks all five slots, one per cycle
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.we = 1'b0;
    nxt_st.done = 1'b0;
    if (st_ff.busy)
    begin
      if (st_ff.pend[st_ff.idx])
      begin
        nxt_st.we = 1'b1;
        nxt_st.waddr = st_ff.addr[st_ff.idx];
        nxt_st.wdata = st_ff.data[st_ff.idx];
        nxt_st.pend[st_ff.idx] = 1'b0;
      end
      if (st_ff.idx == SL_IDX_W'(SL_N - 1))
      begin
        nxt_st.busy = 1'b0;
        nxt_st.done = 1'b1;
      end
      nxt_st.idx = st_ff.idx + 1'b1;
    end
    // done gap stops a double start
    else if (sl.start && !st_ff.done)
    begin
      nxt_st.busy = 1'b1;
      nxt_st.idx = '0;
    end
    // host fills a pair; a late write stays pending
    if (sl.wr && sl.idx < SL_IDX_W'(SL_N))
    begin
      if (sl.is_addr)
        nxt_st.addr[sl.idx] = sl.wdata[PRAM_AW-1:0];
      else
        nxt_st.data[sl.idx] = sl.wdata;
      nxt_st.pend[sl.idx] = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign sl.busy = st_ff.busy;
  assign sl.done = st_ff.done;
  assign sl.pram_we = st_ff.we;
  assign sl.pram_addr = st_ff.waddr;
  assign sl.pram_data = st_ff.wdata;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  pend_only_a: assert property (st_ff.busy && !st_ff.pend[st_ff.idx] |=> !st_ff.we)
    else $error("unwritten pair copied");
  copy_len_a: assert property ($rose(st_ff.busy) |-> ##5 st_ff.done)
    else $error("copy length wrong");
endmodule // dccb_safeload

// ===== dccb_host.sv
`timescale 1ns/1ns
// Host controller on the control port
module dccb_host
  import dccb_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Control port
  output logic wr_o,
  output logic rd_o,
  output logic [dccb_pkg::ADDR_W-1:0] addr_o,
  output logic [dccb_pkg::DATA_W-1:0] wdata_o,
  input wire logic [dccb_pkg::DATA_W-1:0] rdata_i
);
  // Idle port at time zero
  initial
  begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = '0;
    wdata_o = '0;
  end

  // One write strobe; released lines show the inverse, not stale data
  task automatic write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    #1;
    wr_o = 1'b1;
    addr_o = a;
    wdata_o = d;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask

  // Read data is settled one cycle after the strobe edge
  task automatic read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk_i);
    #1;
    rd_o = 1'b1;
    addr_o = a;
    @(posedge clk_i);
    #1;
    rd_o = 1'b0;
    addr_o = ~a;
    d = rdata_i;
  endtask

  task automatic safeload(input logic [DATA_W-1:0] ctl, output logic [DATA_W-1:0] first,
                          output logic [DATA_W-1:0] last);
    int polls;
    write(CORE_CTL, ctl | 16'h0020);
    read(CORE_CTL, first);
    last = first;
    polls = 0;
    // Bounded poll so a stuck trigger cannot hang the host
    while (last[IST_BIT] !== 1'b0 && polls < 20)
    begin
      read(CORE_CTL, last);
      polls++;
    end
  endtask
endmodule // dccb_host

// ===== dsp_core_control_bits_bench.sv
`timescale 1ns/1ns
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module dsp_core_control_bits_bench;
  import dccb_pkg::*;
  logic clk_i, rst_i, wr_i, rd_i, dsp_if_we_i, pram_we_o;
  logic adc_unmute_o, dac_unmute_o, core_run_not_clear_o;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i, rdata_o, dsp_if_data_i, pram_data_o;
  logic [2:0] dsp_if_idx_i;
  logic [GPIO_W-1:0] gpio_pin_i, gpio_setting_o;
  logic [AUX_N-1:0][AUX_W-1:0] aux_adc_i, aux_data_o;
  logic [IF_N-1:0][DATA_W-1:0] if_regs_o;
  logic [1:0] rate_multiplier_o;
  logic [10:0] instr_per_sample_o;
  logic [PRAM_AW-1:0] pram_addr_o;
  logic [PRAM_AW-1:0] qa[$];
  logic [DATA_W-1:0] qd[$];
  int n_errors = 0;
  int samples_checked = 0;
  int n_cycles = 0;
  // Small debounce counts keep the run short
  dccb_core_ctl #(.DEB_CYC_00_P(20), .DEB_CYC_01_P(40), .DEB_CYC_10_P(10), .DEB_CYC_11_P(5)) u_dccb_core_ctl (
    .clk_i(clk_i), .rst_i(rst_i), .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .rdata_o(rdata_o), .dsp_if_we_i(dsp_if_we_i), .dsp_if_idx_i(dsp_if_idx_i),
    .dsp_if_data_i(dsp_if_data_i), .gpio_pin_i(gpio_pin_i), .aux_adc_i(aux_adc_i),
    .if_regs_o(if_regs_o), .gpio_setting_o(gpio_setting_o), .aux_data_o(aux_data_o),
    .adc_unmute_o(adc_unmute_o), .dac_unmute_o(dac_unmute_o),
    .core_run_not_clear_o(core_run_not_clear_o), .rate_multiplier_o(rate_multiplier_o),
    .instr_per_sample_o(instr_per_sample_o), .pram_we_o(pram_we_o), .pram_addr_o(pram_addr_o),
    .pram_data_o(pram_data_o));
  dccb_host u_dccb_host (.clk_i(clk_i), .wr_o(wr_i), .rd_o(rd_i), .addr_o(addr_i),
    .wdata_o(wdata_i), .rdata_i(rdata_o));

  // Clock
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Verdict and end of run
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Hang guard, well above the expected few hundred cycles
  always @(posedge clk_i)
  begin
    n_cycles++;
    if (n_cycles == 20000)
    begin
      n_errors++;
      test_done();
    end
  end

  // Capture parameter RAM writes
  always @(posedge clk_i)
  begin
    if (pram_we_o === 1'b1)
    begin
      qa.push_back(pram_addr_o);
      qd.push_back(pram_data_o);
    end
  end

  // Program-side write to an interface register
  task automatic prog(input logic [2:0] idx, input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    #1;
    dsp_if_we_i = 1'b1;
    dsp_if_idx_i = idx;
    dsp_if_data_i = d;
    @(posedge clk_i);
    #1;
    dsp_if_we_i = 1'b0;
    dsp_if_data_i = ~d;
  endtask

  // Cycles from a pin change until the setting follows
  task automatic deb(input logic [1:0] code, input int t, input logic [GPIO_W-1:0] p);
    int n;
    u_dccb_host.write(CORE_CTL, {2'h0, code, 12'h01C});
    gpio_pin_i = p;
    n = 0;
    while (gpio_setting_o !== p && n < 200)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    `CHK(n >= t - 1 && n <= t + 4, 1'b1)
  endtask

  // Safeload run with expected copied pairs
  task automatic sl_run(input logic [DATA_W-1:0] ctl, input int cnt);
    logic [DATA_W-1:0] f, l;
    qa.delete();
    qd.delete();
    u_dccb_host.safeload(ctl, f, l);
    `CHK(f[IST_BIT], 1'b1)
    `CHK(l[IST_BIT], 1'b0)
    `CHK(qa.size(), cnt)
  endtask

  localparam logic [1:0] REXP [4] = '{RATE_1X, RATE_2X, RATE_4X, RATE_1X};
  localparam logic [10:0] IEXP [4] = '{IPF_1X, IPF_2X, IPF_4X, IPF_1X};
  localparam int DEXP [4] = '{20, 40, 10, 5};
  localparam logic [GPIO_W-1:0] PEXP [4] = '{12'h0A5, 12'h05A, 12'h0FF, 12'h000};

  initial
  begin
    logic [DATA_W-1:0] v;
    rst_i = 1'b1;
    dsp_if_we_i = 1'b0;
    dsp_if_idx_i = 3'h0;
    dsp_if_data_i = 16'h0000;
    gpio_pin_i = 12'h000;
    aux_adc_i = '0;
    repeat (3) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    u_dccb_host.read(CORE_CTL, v);
    `CHK(v, 16'h0000)
    `CHK({adc_unmute_o, dac_unmute_o, core_run_not_clear_o}, 3'h0)
    `CHK(instr_per_sample_o, IPF_1X)
    $display("test reset done");
    u_dccb_host.write(CORE_CTL, 16'hCE1C);
    u_dccb_host.read(CORE_CTL, v);
    `CHK(v, 16'h001C)
    `CHK({adc_unmute_o, dac_unmute_o, core_run_not_clear_o}, 3'h7)
    for (int i = 0; i < 4; i++)
    begin
      u_dccb_host.write(CORE_CTL, 16'h001C | 16'(i));
      @(posedge clk_i);
      #1;
      `CHK(rate_multiplier_o, REXP[i])
      `CHK(instr_per_sample_o, IEXP[i])
    end
    $display("test rate done");
    for (int i = 0; i < 4; i++)
      deb(2'(i), DEXP[i], PEXP[i]);
    u_dccb_host.write(GPIO_SET, 16'h0ABC);
    `CHK(gpio_setting_o, 12'h000)
    $display("test debounce done");
    u_dccb_host.write(IF_BASE, 16'h1111);
    prog(3'h1, 16'hA5A5);
    `CHK(if_regs_o[0], 16'h0000)
    `CHK(if_regs_o[1], 16'hA5A5)
    u_dccb_host.write(CORE_CTL, 16'h005C);
    u_dccb_host.write(IF_LAST, 16'h7777);
    prog(3'h1, 16'h1234);
    `CHK(if_regs_o[7], 16'h7777)
    `CHK(if_regs_o[1], 16'hA5A5)
    $display("test interface done");
    aux_adc_i = {12'h444, 12'h333, 12'h222, 12'h111};
    u_dccb_host.write(AUX_BASE, 16'h0123);
    `CHK(aux_data_o, {12'h444, 12'h333, 12'h222, 12'h111})
    u_dccb_host.write(CORE_CTL, 16'h01DC);
    u_dccb_host.write(AUX_BASE, 16'h0123);
    u_dccb_host.write(GPIO_SET, 16'h0ABC);
    aux_adc_i = '0;
    gpio_pin_i = 12'h777;
    repeat (50) @(posedge clk_i);
    #1;
    `CHK(aux_data_o, {12'h444, 12'h333, 12'h222, 12'h123})
    `CHK(gpio_setting_o, 12'hABC)
    $display("test override done");
    for (int k = 0; k < SL_N; k++)
    begin
      u_dccb_host.write(SL_DATA_BASE + 12'(k), 16'hD000 + 16'(k));
      u_dccb_host.write(SL_ADDR_BASE + 12'(k), 16'h0100 + 16'(k));
    end
    sl_run(16'h01DC, 5);
    for (int k = 0; k < SL_N && k < qa.size(); k++)
    begin
      `CHK(qa[k], 10'h100 + 10'(k))
      `CHK(qd[k], 16'hD000 + 16'(k))
    end
    u_dccb_host.write(SL_DATA_BASE + 12'h001, 16'hBEEF);
    u_dccb_host.write(SL_ADDR_BASE + 12'h003, 16'h0333);
    sl_run(16'h01DC, 2);
    if (qa.size() == 2)
    begin
      `CHK({qa[0], qd[0]}, {10'h101, 16'hBEEF})
      `CHK({qa[1], qd[1]}, {10'h333, 16'hD003})
    end
    sl_run(16'h01DC, 0);
    $display("test safeload done");
    test_done();
  end
endmodule // dsp_core_control_bits_bench
